// ---- mbs_device.sv ----
// Device end: processor port decode, register access and reset handling
//
// Behaviour
// - Power-up reset pulse about 5 us, capacitor lengthens
// - Bus reset line low puts device in reset
// - Register 8 bit 7 shows live reset level
// - Register 5 bit 6 latches bus reset
// - Reset output low during power-up reset
// - Bus reset drives reset output unless disabled
// - Initiator or target pulls select line low
// - Polarity pins invert address bits 5-7 compare
// - Polarity pins 111 select addresses below 32
// - Strap low: lines 0-2 pick register
// - Board holds bus style strap low
// - Address latched on latch strobe falling edge
// - Read and write strobes honoured only while qualifier high
// - Processor pulses read strobe to read
// - Processor pulses write strobe to write
`timescale 1ns/1ps
module mbs_device (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    mbs_link_if.device       link,
    output logic             internal_reset_out,
    output logic             reg_write_out,
    output logic [4:0]       reg_index_out,
    output logic [7:0]       reg_wdata_out,
    output logic             scsi_reset_flag_out
);
    logic [8:0]  ctl_s;
    logic [13:0] dat_s;
    logic        ale_s;
    logic        qual_s;
    logic        rd_b_s;
    logic        wr_b_s;
    logic        cs_b_s;
    logic        cap_s;
    logic        scsi_rst_b_s;
    logic        mode_s;
    logic        style_s;
    logic [2:0]  pol_b_s;
    logic [2:0]  regsel_s;
    logic [7:0]  ad_s;
    logic        ale_d;
    logic        rd_b_d;
    logic        wr_b_d;
    logic [7:0]  por_cnt;
    logic        por_active;
    logic        scsi_rst_act;
    logic        core_reset;
    logic [7:0]  addr_latched;
    logic [7:0]  sel_ctrl;
    logic [7:0]  aux_ctrl;
    logic [7:0]  rdata;
    logic [7:0]  next_rdata;
    logic        scsi_reset_flag;
    logic        reading;
    logic        reset_out_b;
    logic        chip_sel;
    logic        access_en;
    logic        ale_fall;
    logic        rd_fall;
    logic        rd_rise;
    logic        wr_en;
    logic [4:0]  reg_idx;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    mbs_sync #(
        .W       (9),
        .RST_VAL (mbs_pkg::DEV_SYNC_RST)
    ) u_ctl_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .d_in     ({link.address_latch_strobe, link.strobe_qualifier,
                    link.read_strobe_b, link.write_strobe_b, link.chip_select_b,
                    link.reset_timing_capacitor, link.scsi_rst_b,
                    link.address_mode_strap, link.bus_style_strap}),
        .q_out    (ctl_s)
    );

    mbs_sync #(
        .W       (14),
        .RST_VAL (14'h0000)
    ) u_dat_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .d_in     ({link.addr_polarity_sel_b, link.register_select_lines, link.ad}),
        .q_out    (dat_s)
    );

    assign {ale_s, qual_s, rd_b_s, wr_b_s, cs_b_s, cap_s, scsi_rst_b_s,
            mode_s, style_s} = ctl_s;
    assign {pol_b_s, regsel_s, ad_s} = dat_s;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ale_d  <= 1'b0;
            rd_b_d <= 1'b1;
            wr_b_d <= 1'b1;
        end else begin
            ale_d  <= ale_s;
            rd_b_d <= rd_b_s;
            wr_b_d <= wr_b_s;
        end
    end

    assign ale_fall = ale_d & !ale_s;
    assign rd_fall  = rd_b_d & !rd_b_s;
    assign rd_rise  = !rd_b_d & rd_b_s;

    // ----------------------------------------------------------------
    // Power-up and bus reset
    // ----------------------------------------------------------------
    // power-up pulse timer
    // Capacitor pin held low restarts the count, so it only lengthens
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            por_cnt    <= 8'h00;
            por_active <= 1'b1;
        end else if (!cap_s) begin
            por_cnt    <= 8'h00;
            por_active <= 1'b1;
        end else if (por_cnt == mbs_pkg::POR_LAST) begin
            por_active <= 1'b0;
        end else begin
            por_cnt <= por_cnt + 8'h01;
        end
    end

    assign scsi_rst_act = !scsi_rst_b_s;
    assign core_reset   = por_active | scsi_rst_act;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reset_out_b <= 1'b0;
        end else begin
            reset_out_b <= !(por_active
                           | (scsi_rst_act & !aux_ctrl[mbs_pkg::AUX_DIS_RST_BIT]));
        end
    end

    // sticky bus reset flag
    // Set wins over the read clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scsi_reset_flag <= 1'b0;
        end else if (por_active) begin
            scsi_reset_flag <= 1'b0;
        end else if (scsi_rst_act) begin
            scsi_reset_flag <= 1'b1;
        end else if (reading && rd_rise && reg_idx == mbs_pkg::REG_INT_STATUS) begin
            scsi_reset_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Address latch and decode
    // ----------------------------------------------------------------
    // latch on strobe fall
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            addr_latched <= 8'h00;
        end else if (core_reset) begin
            addr_latched <= 8'h00;
        end else if (ale_fall) begin
            addr_latched <= ad_s;
        end
    end

    // pins 111 need bits 7:5 zero
    assign chip_sel = mode_s ? ((addr_latched[7:5] ^ ~pol_b_s) == mbs_pkg::CS_MATCH)
                             : !cs_b_s;
    assign reg_idx  = mode_s ? addr_latched[4:0] : {2'b00, regsel_s};

    assign access_en = !style_s & qual_s & chip_sel;
    assign wr_en     = wr_b_d & !wr_b_s & access_en & !core_reset;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Survives bus reset, else the disable bit could never work
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            aux_ctrl <= mbs_pkg::AUX_CTRL_RST;
        end else if (por_active) begin
            aux_ctrl <= mbs_pkg::AUX_CTRL_RST;
        end else if (wr_en && reg_idx == mbs_pkg::REG_AUX_CTRL) begin
            aux_ctrl <= ad_s;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel_ctrl <= mbs_pkg::SEL_CTRL_RST;
        end else if (core_reset) begin
            sel_ctrl <= mbs_pkg::SEL_CTRL_RST;
        end else if (wr_en && reg_idx == mbs_pkg::REG_SEL_CTRL) begin
            sel_ctrl <= ad_s;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_write_out <= 1'b0;
            reg_index_out <= 5'h00;
            reg_wdata_out <= 8'h00;
        end else begin
            reg_write_out <= wr_en;
            if (wr_en) begin
                reg_index_out <= reg_idx;
                reg_wdata_out <= ad_s;
            end
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        case (reg_idx)
            mbs_pkg::REG_SEL_CTRL: begin
                next_rdata = sel_ctrl;
            end
            mbs_pkg::REG_INT_STATUS: begin
                next_rdata[mbs_pkg::INT_SCSI_RST_BIT] = scsi_reset_flag;
            end
            mbs_pkg::REG_INPUT_PORT: begin
                next_rdata[mbs_pkg::IN_RST_PIN_BIT] = scsi_rst_b_s;
            end
            mbs_pkg::REG_AUX_CTRL: begin
                next_rdata = aux_ctrl;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // read strobe drives data out
    // Data frozen at strobe fall so the bus stays stable
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reading <= 1'b0;
            rdata   <= 8'h00;
        end else if (core_reset) begin
            reading <= 1'b0;
        end else if (rd_fall && access_en) begin
            reading <= 1'b1;
            rdata   <= next_rdata;
        end else if (rd_b_s) begin
            reading <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    assign link.dev_ad            = rdata;
    assign link.dev_ad_oe_b       = !reading;
    assign link.reset_out_b       = reset_out_b;
    // Bus reset is only sensed here, never driven
    assign link.dev_scsi_rst      = 1'b0;
    assign link.dev_scsi_rst_oe_b = 1'b1;
    assign link.dev_sel           = 1'b0;
    assign link.dev_sel_oe_b      = !sel_ctrl[mbs_pkg::SEL_DRIVE_BIT];

    assign internal_reset_out  = core_reset;
    assign scsi_reset_flag_out = scsi_reset_flag;
endmodule

// ---- mbs_pkg.sv ----
// Shared constants and types for the host port and reset block
package mbs_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_MHZ           = 25;
    localparam int          POR_TIME_NS       = 5000;
    // Least time, so round up
    localparam int          POR_CYCLES        = (POR_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  POR_LAST          = 8'(POR_CYCLES - 1);
    localparam int          HOST_PHASE_CYCLES = 8;
    localparam logic [3:0]  PHASE_LAST        = 4'(HOST_PHASE_CYCLES - 1);
    // ----------------------------------------------------------------
    // Device register indices and fields
    // ----------------------------------------------------------------
    localparam logic [4:0]  REG_SEL_CTRL      = 5'h01;
    localparam logic [4:0]  REG_INT_STATUS    = 5'h05;
    localparam logic [4:0]  REG_INPUT_PORT    = 5'h08;
    localparam logic [4:0]  REG_AUX_CTRL      = 5'h13;
    localparam int          SEL_DRIVE_BIT     = 0;
    localparam int          INT_SCSI_RST_BIT  = 6;
    localparam int          IN_RST_PIN_BIT    = 7;
    localparam int          AUX_DIS_RST_BIT   = 4;
    localparam logic [7:0]  SEL_CTRL_RST      = 8'h00;
    localparam logic [7:0]  AUX_CTRL_RST      = 8'h00;
    localparam logic [7:0]  BUS_IDLE          = 8'hff;
    localparam logic [2:0]  CS_MATCH          = 3'h0;
    localparam logic [8:0]  DEV_SYNC_RST      = 9'h07c;
    localparam logic [10:0] HOST_SYNC_RST     = 11'h7ff;
    // ----------------------------------------------------------------
    // Host controller APB map
    // ----------------------------------------------------------------
    localparam logic [11:0] APB_CTRL          = 12'h000;
    localparam logic [11:0] APB_CMD           = 12'h004;
    localparam logic [11:0] APB_STATUS        = 12'h008;
    localparam int          CTRL_MODE_BIT     = 0;
    localparam int          CTRL_POL_LSB      = 1;
    localparam int          CTRL_STYLE_BIT    = 4;
    localparam int          CTRL_SCSI_RST_BIT = 5;
    localparam int          CTRL_SEL_BIT      = 6;
    localparam int          CTRL_QUAL_OFF_BIT = 7;
    localparam int          CTRL_CAP_HOLD_BIT = 8;
    localparam logic [8:0]  CTRL_RST          = 9'h00f;
    localparam int          CMD_DATA_LSB      = 8;
    localparam int          CMD_READ_BIT      = 16;
    localparam int          ST_RDATA_LSB      = 8;

    typedef enum logic [2:0] {
        H_IDLE,
        H_ADDR,
        H_LATCH,
        H_SETUP,
        H_STROBE,
        H_HOLD
    } mbs_host_state_t;
endpackage

// ---- mbs_link_if.sv ----
// Pins between the processor side and the bus interface device
`timescale 1ns/1ps
interface mbs_link_if;
    logic [7:0] host_ad;
    logic       host_ad_oe_b;
    logic       address_latch_strobe;
    logic       strobe_qualifier;
    logic       read_strobe_b;
    logic       write_strobe_b;
    logic [2:0] register_select_lines;
    logic       chip_select_b;
    logic       address_mode_strap;
    logic       bus_style_strap;
    logic [2:0] addr_polarity_sel_b;
    logic       reset_timing_capacitor;
    logic       host_scsi_rst;
    logic       host_scsi_rst_oe_b;
    logic       host_sel;
    logic       host_sel_oe_b;
    logic [7:0] dev_ad;
    logic       dev_ad_oe_b;
    logic       reset_out_b;
    logic       dev_scsi_rst;
    logic       dev_scsi_rst_oe_b;
    logic       dev_sel;
    logic       dev_sel_oe_b;
    // Resolved wire levels, pulled high when nobody drives
    logic [7:0] ad;
    logic       scsi_rst_b;
    logic       sel_b;

    assign ad = !host_ad_oe_b ? host_ad : (!dev_ad_oe_b ? dev_ad : mbs_pkg::BUS_IDLE);
    assign scsi_rst_b = (host_scsi_rst_oe_b | host_scsi_rst)
                      & (dev_scsi_rst_oe_b | dev_scsi_rst);
    assign sel_b = (host_sel_oe_b | host_sel) & (dev_sel_oe_b | dev_sel);

    modport device (
        input  address_latch_strobe, strobe_qualifier, read_strobe_b, write_strobe_b,
        input  register_select_lines, chip_select_b, address_mode_strap, bus_style_strap,
        input  addr_polarity_sel_b, reset_timing_capacitor, ad, scsi_rst_b,
        output dev_ad, dev_ad_oe_b, reset_out_b, dev_scsi_rst, dev_scsi_rst_oe_b,
        output dev_sel, dev_sel_oe_b
    );
    modport host (
        input  ad, reset_out_b, scsi_rst_b, sel_b,
        output host_ad, host_ad_oe_b, address_latch_strobe, strobe_qualifier,
        output read_strobe_b, write_strobe_b, register_select_lines, chip_select_b,
        output address_mode_strap, bus_style_strap, addr_polarity_sel_b,
        output reset_timing_capacitor, host_scsi_rst, host_scsi_rst_oe_b,
        output host_sel, host_sel_oe_b
    );
endinterface

// ---- mbs_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module mbs_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta;

    // First stage feeds the second stage only
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta  <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule

// ---- mbs_host.sv ----
// Processor end: APB-controlled sequencer for the multiplexed port
`timescale 1ns/1ps
module mbs_host (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    mbs_link_if.host         link
);
    logic [8:0]              ctrl;
    logic [7:0]              cmd_addr;
    logic [7:0]              cmd_data;
    logic                    cmd_read;
    logic [7:0]              rd_byte;
    logic [10:0]             pin_s;
    logic [3:0]              phase_cnt;
    logic                    phase_done;
    logic                    apb_write;
    logic                    mapped;
    logic                    start;
    logic                    drive_addr;
    logic [31:0]             next_prdata;
    mbs_pkg::mbs_host_state_t state;
    mbs_pkg::mbs_host_state_t next_state;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign pready_out  = 1'b1;
    assign apb_write   = psel_in & penable_in & pwrite_in;
    assign mapped      = (paddr_in == mbs_pkg::APB_CTRL) | (paddr_in == mbs_pkg::APB_CMD)
                       | (paddr_in == mbs_pkg::APB_STATUS);
    assign pslverr_out = psel_in & penable_in & !mapped;
    // Busy sequencer ignores new commands
    assign start       = apb_write & (paddr_in == mbs_pkg::APB_CMD) & (state == mbs_pkg::H_IDLE);

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (paddr_in == mbs_pkg::APB_CTRL) begin
            next_prdata[8:0] = ctrl;
        end else if (paddr_in == mbs_pkg::APB_STATUS) begin
            next_prdata[0]     = (state != mbs_pkg::H_IDLE);
            next_prdata[15:8]  = rd_byte;
            next_prdata[18:16] = pin_s[2:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in) begin
            prdata_out <= next_prdata;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl <= mbs_pkg::CTRL_RST;
        end else if (apb_write && paddr_in == mbs_pkg::APB_CTRL) begin
            ctrl <= pwdata_in[8:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmd_addr <= 8'h00;
            cmd_data <= 8'h00;
            cmd_read <= 1'b0;
        end else if (start) begin
            cmd_addr <= pwdata_in[7:0];
            cmd_data <= pwdata_in[mbs_pkg::CMD_DATA_LSB +: 8];
            cmd_read <= pwdata_in[mbs_pkg::CMD_READ_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Access sequencer
    // ----------------------------------------------------------------
    // Pins from the device pass two flops like any pin
    mbs_sync #(
        .W       (11),
        .RST_VAL (mbs_pkg::HOST_SYNC_RST)
    ) u_pin_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .d_in     ({link.ad, link.reset_out_b, link.scsi_rst_b, link.sel_b}),
        .q_out    (pin_s)
    );

    assign phase_done = (phase_cnt == mbs_pkg::PHASE_LAST);

    always_comb begin
        next_state = state;
        case (state)
            mbs_pkg::H_IDLE:   if (start) next_state = mbs_pkg::H_ADDR;
            mbs_pkg::H_ADDR:   if (phase_done) next_state = mbs_pkg::H_LATCH;
            mbs_pkg::H_LATCH:  if (phase_done) next_state = mbs_pkg::H_SETUP;
            mbs_pkg::H_SETUP:  if (phase_done) next_state = mbs_pkg::H_STROBE;
            mbs_pkg::H_STROBE: if (phase_done) next_state = mbs_pkg::H_HOLD;
            mbs_pkg::H_HOLD:   if (phase_done) next_state = mbs_pkg::H_IDLE;
            default:           next_state = mbs_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state     <= mbs_pkg::H_IDLE;
            phase_cnt <= 4'h0;
        end else begin
            state     <= next_state;
            phase_cnt <= (next_state != state) ? 4'h0 : phase_cnt + 4'h1;
        end
    end

    // Sampled late in the strobe, after device and sync latency
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_byte <= 8'h00;
        end else if (state == mbs_pkg::H_STROBE && phase_done && cmd_read) begin
            rd_byte <= pin_s[10:3];
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    assign drive_addr = (state == mbs_pkg::H_ADDR) | (state == mbs_pkg::H_LATCH);
    assign link.host_ad              = drive_addr ? cmd_addr : cmd_data;
    assign link.host_ad_oe_b         = !(drive_addr | (!cmd_read & (state == mbs_pkg::H_SETUP
                                     | state == mbs_pkg::H_STROBE | state == mbs_pkg::H_HOLD)));
    assign link.address_latch_strobe = (state == mbs_pkg::H_ADDR);
    assign link.strobe_qualifier     = !ctrl[mbs_pkg::CTRL_QUAL_OFF_BIT];
    assign link.read_strobe_b        = !((state == mbs_pkg::H_STROBE) & cmd_read);
    assign link.write_strobe_b       = !((state == mbs_pkg::H_STROBE) & !cmd_read);
    assign link.register_select_lines = cmd_addr[2:0];
    assign link.chip_select_b        = (state == mbs_pkg::H_IDLE);
    assign link.address_mode_strap   = ctrl[mbs_pkg::CTRL_MODE_BIT];
    assign link.addr_polarity_sel_b  = ctrl[mbs_pkg::CTRL_POL_LSB +: 3];
    assign link.bus_style_strap      = ctrl[mbs_pkg::CTRL_STYLE_BIT];
    assign link.reset_timing_capacitor = !ctrl[mbs_pkg::CTRL_CAP_HOLD_BIT];
    assign link.host_scsi_rst        = 1'b0;
    assign link.host_scsi_rst_oe_b   = !ctrl[mbs_pkg::CTRL_SCSI_RST_BIT];
    assign link.host_sel             = 1'b0;
    assign link.host_sel_oe_b        = !ctrl[mbs_pkg::CTRL_SEL_BIT];
endmodule

// ---- mbs_link_assertions.sv ----
// Concurrent checks on the host to device link
`timescale 1ns/1ps
module mbs_link_assertions (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic [7:0] host_ad,
    input  wire logic       address_latch_strobe,
    input  wire logic       strobe_qualifier,
    input  wire logic       read_strobe_b,
    input  wire logic       write_strobe_b,
    input  wire logic       reset_timing_capacitor,
    input  wire logic       scsi_rst_b,
    input  wire logic       dev_ad_oe_b,
    input  wire logic       reset_out_b
);
    // ----
    // Cycles since reset release, saturating
    // ----
    logic [7:0] por_cnt;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            por_cnt <= 8'h00;
        end else if (por_cnt != 8'hff) begin
            por_cnt <= por_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    a_por_min_len: assert property ($rose(reset_out_b) |-> por_cnt >= 8'(mbs_pkg::POR_CYCLES))
        else $error("reset output released too early");
    a_por_max_len: assert property ($rose(rst_b_in) |-> ##[120:140] reset_out_b)
        else $error("reset output not released in time");
    a_cap_holds_rst: assert property (!reset_timing_capacitor [*5] |-> !reset_out_b)
        else $error("reset output high while capacitor low");
    a_drive_in_strobe: assert property ($fell(dev_ad_oe_b) |-> !read_strobe_b && strobe_qualifier)
        else $error("device drove bus outside qualified read");
    a_unqual_no_drive: assert property (!strobe_qualifier [*6] |-> dev_ad_oe_b)
        else $error("device drove bus with qualifier low");
    a_bus_rst_idle: assert property (!scsi_rst_b [*6] |-> dev_ad_oe_b)
        else $error("device drove bus during bus reset");
    a_strobe_excl: assert property (!(!read_strobe_b && !write_strobe_b))
        else $error("read and write strobes low together");
    a_latch_addr_hold: assert property ($fell(address_latch_strobe) |->
        ($stable(host_ad) && read_strobe_b && write_strobe_b) [*6])
        else $error("address not held after latch strobe fall");
    cover property ($rose(reset_out_b));
    cover property ($fell(dev_ad_oe_b));
    cover property ($fell(scsi_rst_b));
endmodule

// ---- testbench.sv ----
// Self-checking bench for the host port pair driven over APB
`timescale 1ns/1ps
module testbench;
    logic        clk_in     = 1'b0;
    logic        rst_b_in   = 1'b0;
    logic        psel_in    = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in  = 1'b0;
    logic [11:0] paddr_in   = 12'h000;
    logic [31:0] pwdata_in  = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  b;
    int          errors     = 0;
    int          n_tests    = 0;
    mbs_link_if lnk ();
    always #20 clk_in = ~clk_in;
    mbs_host u_mbs_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .link(lnk));
    mbs_device u_mbs_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(lnk),
        .internal_reset_out(), .reg_write_out(), .reg_index_out(), .reg_wdata_out(),
        .scsi_reset_flag_out());
    mbs_link_assertions u_mbs_link_assertions (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .host_ad(lnk.host_ad), .address_latch_strobe(lnk.address_latch_strobe),
        .strobe_qualifier(lnk.strobe_qualifier), .read_strobe_b(lnk.read_strobe_b),
        .write_strobe_b(lnk.write_strobe_b), .reset_timing_capacitor(lnk.reset_timing_capacitor),
        .scsi_rst_b(lnk.scsi_rst_b), .dev_ad_oe_b(lnk.dev_ad_oe_b), .reset_out_b(lnk.reset_out_b));
    // ----
    // Tasks
    // ----
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1) begin
            // Bounded wait, a stuck slave ends the run
            if (++k > 16) begin errors++; end_sim(); end
            @(posedge clk_in);
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic dev(input logic [16:0] cmd);
        apb(1'b1, mbs_pkg::APB_CMD, {15'h0, cmd});
        rd = 32'h1;
        for (int k = 0; k < 40 && rd[0] !== 1'b0; k++) apb(1'b0, mbs_pkg::APB_STATUS, 32'h0);
        if (rd[0] !== 1'b0) begin errors++; end_sim(); end
        b = rd[15:8];
    endtask
    task automatic rchk(input logic [8:0] c, input logic [7:0] a, input logic [7:0] e);
        apb(1'b1, mbs_pkg::APB_CTRL, {23'h0, c});
        dev({1'b1, 8'h00, a});
        chk("dev read", {24'h0, e}, {24'h0, b});
    endtask
    task automatic sts(input int i, input logic e);
        repeat (10) @(posedge clk_in);
        apb(1'b0, mbs_pkg::APB_STATUS, 32'h0);
        chk("status bit", {31'h0, e}, {31'h0, rd[i]});
    endtask
    task automatic por_wait();
        int n = 0;
        while (lnk.reset_out_b !== 1'b1 && n < 300) begin @(posedge clk_in); n++; end
        chk("por length", 32'h1, 32'(n >= 126 && n <= 140));
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        por_wait();
        apb(1'b0, mbs_pkg::APB_CTRL, 32'h0);
        chk("ctrl reset", 32'h00f, rd);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        apb(1'b1, mbs_pkg::APB_CTRL, 32'h10f);
        sts(18, 1'b0);
        apb(1'b1, mbs_pkg::APB_CTRL, 32'h00f);
        por_wait();
        $display("test reset done");
        dev({1'b1, 8'h00, 8'h08});
        chk("live level", 32'h1, {31'h0, b[7]});
        apb(1'b1, mbs_pkg::APB_CTRL, 32'h02f);
        sts(17, 1'b0);
        sts(18, 1'b0);
        apb(1'b1, mbs_pkg::APB_CTRL, 32'h00f);
        sts(18, 1'b1);
        dev({1'b1, 8'h00, 8'h05});
        chk("flag set", 32'h1, {31'h0, b[6]});
        dev({1'b1, 8'h00, 8'h05});
        chk("flag clear", 32'h0, {31'h0, b[6]});
        dev({1'b0, 8'h10, 8'h13});
        dev({1'b0, 8'h01, 8'h01});
        sts(16, 1'b0);
        apb(1'b1, mbs_pkg::APB_CTRL, 32'h02f);
        sts(18, 1'b1);
        apb(1'b1, mbs_pkg::APB_CTRL, 32'h00f);
        sts(16, 1'b1);
        $display("test bus reset done");
        for (int p = 0; p < 8; p++) begin
            rchk({5'h00, 3'(p), 1'b1}, {~3'(p), 5'h13}, 8'h10);
            rchk({5'h00, 3'(p), 1'b1}, {~3'(p) ^ 3'h4, 5'h13}, 8'hff);
        end
        $display("test polarity done");
        rchk(9'h08f, 8'h13, 8'hff);
        rchk(9'h01f, 8'h13, 8'hff);
        dev({1'b0, 8'h00, 8'h13});
        rchk(9'h00f, 8'h13, 8'h10);
        apb(1'b1, mbs_pkg::APB_CTRL, 32'h00e);
        dev({1'b0, 8'h01, 8'h09});
        sts(16, 1'b0);
        dev({1'b0, 8'h00, 8'h09});
        sts(16, 1'b1);
        $display("test access gating done");
        end_sim();
    end
endmodule
